// ---- design/rsxs_consts.svh ----
// Constants for the rotate/subtract/swap/xor execution datapath.
// Assumes inclusion by bare name from design files only.
`ifndef RSXS_CONSTS_SVH
`define RSXS_CONSTS_SVH

`define RSXS_DATA_W        8
`define RSXS_ADDR_W        5
`define RSXS_FILE_DEPTH    32
`define RSXS_DIR_SEL_LO    3'h6
`define RSXS_DIR_SEL_HI    3'h7
`define RSXS_DIR_RST       8'hff
`define RSXS_ACC_RST       8'h00
`define RSXS_FILE_RST      8'h00
`define RSXS_NIB_LO_MSB    3
`define RSXS_NIB_HI_LSB    4
`define RSXS_DEST_ACC      1'b0
`define RSXS_DEST_FILE     1'b1

`endif

// ---- design/rsxs_pkg.sv ----
// Types for the rotate/subtract/swap/xor execution datapath.
// Assumes nothing beyond a SystemVerilog compiler.
package rsxs_pkg;

   typedef enum logic [2:0] {
      rotate_left_carry_op,
      rotate_right_carry_op,
      subtract_acc_from_reg_op,
      nibble_exchange_op,
      direction_load_op,
      xor_literal_acc_op,
      xor_acc_reg_op,
      no_op
   } exec_op_t;

   typedef struct packed {
      logic carry;
      logic digit_carry_flag;
      logic zero;
   } status_flags_t;

endpackage

// ---- design/rsxs_alu_if.sv ----
// Interface between the sequencer and its combinational ALU.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface rsxs_alu_if;
   import rsxs_pkg::*;

   exec_op_t      op;
   logic [7:0]    acc;
   logic [7:0]    operand;
   logic          carry_in;
   logic [7:0]    result;
   status_flags_t flags_out;
   logic          carry_we;
   logic          digit_we;
   logic          zero_we;
   logic          result_valid;

   modport seq (output op, output acc, output operand, output carry_in,
                input result, input flags_out, input carry_we, input digit_we,
                input zero_we, input result_valid);
   modport alu (input op, input acc, input operand, input carry_in,
                output result, output flags_out, output carry_we, output digit_we,
                output zero_we, output result_valid);
endinterface

// ---- design/rsxs_alu.sv ----
// Combinational ALU for the rotate/subtract/swap/xor instruction group.
// Assumes operands are stable for the whole instruction cycle.
`timescale 1ns/1ps
`include "rsxs_consts.svh"
module rsxs_alu (
   rsxs_alu_if.alu bus
);
   import rsxs_pkg::*;

   wire [8:0] diff_full;
   wire [4:0] diff_low;
   wire [7:0] rol_res;
   wire [7:0] ror_res;
   wire [7:0] swap_res;
   wire [7:0] xor_lit_res;
   wire [7:0] xor_reg_res;

   // Borrow-style carry: set when no borrow occurred
   assign diff_full   = {1'b0, bus.operand} + {1'b0, ~bus.acc} + 9'h001;
   assign diff_low    = {1'b0, bus.operand[3:0]} + {1'b0, ~bus.acc[3:0]} + 5'h01;
   assign rol_res     = {bus.operand[6:0], bus.carry_in};
   assign ror_res     = {bus.carry_in, bus.operand[7:1]};
   assign swap_res    = {bus.operand[`RSXS_NIB_LO_MSB:0],
                         bus.operand[7:`RSXS_NIB_HI_LSB]};
   assign xor_lit_res = bus.operand ^ bus.acc;
   assign xor_reg_res = bus.operand ^ bus.acc;

   always_comb begin
      bus.result       = 8'h00;
      bus.flags_out    = '0;
      bus.carry_we     = 1'b0;
      bus.digit_we     = 1'b0;
      bus.zero_we      = 1'b0;
      bus.result_valid = 1'b1;
      case (bus.op)
         rotate_left_carry_op: begin
            bus.result          = rol_res;
            bus.flags_out.carry = bus.operand[7];
            bus.carry_we        = 1'b1;
         end
         rotate_right_carry_op: begin
            bus.result          = ror_res;
            bus.flags_out.carry = bus.operand[0];
            bus.carry_we        = 1'b1;
         end
         subtract_acc_from_reg_op: begin
            bus.result                     = diff_full[7:0];
            bus.flags_out.carry            = diff_full[8];
            bus.flags_out.digit_carry_flag = diff_low[4];
            bus.flags_out.zero             = (diff_full[7:0] == 8'h00);
            bus.carry_we                   = 1'b1;
            bus.digit_we                   = 1'b1;
            bus.zero_we                    = 1'b1;
         end
         nibble_exchange_op: begin
            bus.result = swap_res;
         end
         direction_load_op: begin
            bus.result = bus.acc;
         end
         xor_literal_acc_op: begin
            bus.result         = xor_lit_res;
            bus.flags_out.zero = (xor_lit_res == 8'h00);
            bus.zero_we        = 1'b1;
         end
         xor_acc_reg_op: begin
            bus.result         = xor_reg_res;
            bus.flags_out.zero = (xor_reg_res == 8'h00);
            bus.zero_we        = 1'b1;
         end
         default: begin
            bus.result_valid = 1'b0;
         end
      endcase
   end
endmodule

// ---- design/rsxs_exec.sv ----
// Execution datapath for the rotate/subtract/swap/xor/direction group.
// Assumes the decoder presents one decoded instruction per clock with
// exec_valid_in high; operands are synchronous to clock_in.
`timescale 1ns/1ps
`include "rsxs_consts.svh"

module rsxs_exec #(
   parameter int unsigned FILE_DEPTH = `RSXS_FILE_DEPTH
) (
   input  wire logic              clock_in,
   input  wire logic              sys_rst_in,
   input  wire logic              exec_valid_in,
   input  wire rsxs_pkg::exec_op_t op_in,
   input  wire logic [4:0]        file_addr_in,
   input  wire logic              dest_sel_in,
   input  wire logic [7:0]        literal_in,
   output logic [7:0]             acc_out,
   output logic                   carry_out,
   output logic                   digit_carry_out,
   output logic                   zero_out,
   output logic [7:0]             dir_a_out,
   output logic [7:0]             dir_b_out,
   output logic [7:0]             file_rd_data_out,
   output logic                   illegal_dir_out
);
   import rsxs_pkg::*;

   rsxs_alu_if alu_bus ();

   logic [7:0]    file_q [FILE_DEPTH];
   logic [7:0]    acc_q;
   status_flags_t flags_q;
   logic [7:0]    dir_a_q;
   logic [7:0]    dir_b_q;
   logic          illegal_q;

   wire  [7:0] file_rd;
   wire        is_file_op;
   wire        wr_acc;
   wire        wr_file;
   wire        dir_sel_a;
   wire        dir_sel_b;
   wire        do_exec;

   assign file_rd   = file_q[file_addr_in];
   assign do_exec   = exec_valid_in && alu_bus.result_valid;
   assign is_file_op = (op_in != xor_literal_acc_op) && (op_in != direction_load_op);
   // Literal xor always lands in the accumulator
   assign wr_acc    = do_exec && ((op_in == xor_literal_acc_op) ||
                      (is_file_op && dest_sel_in == `RSXS_DEST_ACC));
   assign wr_file   = do_exec && is_file_op && dest_sel_in == `RSXS_DEST_FILE;
   // The low three selector bits pick the register and bits 4:3 must be zero; other codes are flagged, not written
   assign dir_sel_a = do_exec && op_in == direction_load_op &&
                      file_addr_in[2:0] == `RSXS_DIR_SEL_LO && file_addr_in[4:3] == 2'h0;
   assign dir_sel_b = do_exec && op_in == direction_load_op &&
                      file_addr_in[2:0] == `RSXS_DIR_SEL_HI && file_addr_in[4:3] == 2'h0;

   assign alu_bus.op       = op_in;
   assign alu_bus.acc      = acc_q;
   assign alu_bus.operand  = (op_in == xor_literal_acc_op) ? literal_in : file_rd;
   assign alu_bus.carry_in = flags_q.carry;

   rsxs_alu u_alu (
      .bus (alu_bus)
   );

   genvar gi;
   generate
      for (gi = 0; gi < FILE_DEPTH; gi++) begin : g_file
         always_ff @(posedge clock_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
               file_q[gi] <= `RSXS_FILE_RST;
            end else if (wr_file && file_addr_in == 5'(gi)) begin
               file_q[gi] <= alu_bus.result;
            end
         end
      end
   endgenerate

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         acc_q <= `RSXS_ACC_RST;
      end else if (wr_acc) begin
         acc_q <= alu_bus.result;
      end
   end

   // Per-flag write enables keep untouched flags stable
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         flags_q <= '0;
      end else if (do_exec) begin
         if (alu_bus.carry_we) begin
            flags_q.carry <= alu_bus.flags_out.carry;
         end
         if (alu_bus.digit_we) begin
            flags_q.digit_carry_flag <= alu_bus.flags_out.digit_carry_flag;
         end
         if (alu_bus.zero_we) begin
            flags_q.zero <= alu_bus.flags_out.zero;
         end
      end
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         dir_a_q   <= `RSXS_DIR_RST;
         dir_b_q   <= `RSXS_DIR_RST;
         illegal_q <= 1'b0;
      end else begin
         if (dir_sel_a) begin
            dir_a_q <= acc_q;
         end
         if (dir_sel_b) begin
            dir_b_q <= acc_q;
         end
         illegal_q <= do_exec && op_in == direction_load_op && !dir_sel_a && !dir_sel_b;
      end
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         file_rd_data_out <= 8'h00;
      end else begin
         file_rd_data_out <= file_rd;
      end
   end

   assign acc_out         = acc_q;
   assign carry_out       = flags_q.carry;
   assign digit_carry_out = flags_q.digit_carry_flag;
   assign zero_out        = flags_q.zero;
   assign dir_a_out       = dir_a_q;
   assign dir_b_out       = dir_b_q;
   assign illegal_dir_out = illegal_q;
endmodule

// ---- test/rsxs_decoder_model.sv ----
// Decoder stand-in: issues one random decoded instruction per clock.
// Assumes the datapath samples its inputs on the rising clock edge.
`timescale 1ns/1ps
module rsxs_decoder_model (
   input  wire logic          clock_in,
   input  wire logic          sys_rst_in,
   output logic               exec_valid_out,
   output rsxs_pkg::exec_op_t op_out,
   output logic [4:0]         file_addr_out,
   output logic               dest_sel_out,
   output logic [7:0]         literal_out
);
   import rsxs_pkg::*;
   exec_op_t   o;
   logic [4:0] a;
   initial begin
      void'($urandom(32'h7749));
      exec_valid_out = 1'b0;
      op_out = no_op;
      file_addr_out = 5'h00;
      dest_sel_out = 1'b0;
      literal_out = 8'h00;
      forever begin
         @(posedge clock_in);
         #1;
         o = exec_op_t'($urandom % 8);
         a = 5'($urandom);
         // Selector 5..8 so both legal and refused loads occur
         if (o == direction_load_op) a = 5'(5 + $urandom % 4);
         exec_valid_out = !sys_rst_in && ($urandom % 8 != 0);
         op_out = o;
         file_addr_out = a;
         dest_sel_out = 1'($urandom);
         literal_out = 8'($urandom);
      end
   end
endmodule

// ---- test/rsxs_exec_chk.sv ----
// Port-level checks of the execution datapath.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/1ps
module rsxs_exec_chk (
   input wire logic               clock_in,
   input wire logic               sys_rst_in,
   input wire logic               exec_valid_in,
   input wire rsxs_pkg::exec_op_t op_in,
   input wire logic [4:0]         file_addr_in,
   input wire logic               dest_sel_in,
   input wire logic [7:0]         literal_in,
   input wire logic [7:0]         acc_out,
   input wire logic               carry_out,
   input wire logic               digit_carry_out,
   input wire logic               zero_out,
   input wire logic [7:0]         dir_a_out,
   input wire logic [7:0]         dir_b_out
);
   import rsxs_pkg::*;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   sequence s_exec(exec_op_t o);
      exec_valid_in && op_in == o;
   endsequence
   property p_kept(exec_op_t o);
      s_exec(o) |=> $stable({carry_out, digit_carry_out, zero_out});
   endproperty
   AST_SWAP_FLAGS: assert property (p_kept(nibble_exchange_op))
      else $error("swap changed a flag");
   AST_DIR_FLAGS: assert property (p_kept(direction_load_op))
      else $error("direction load changed a flag");
   AST_ROTL_BIT: assert property (s_exec(rotate_left_carry_op) ##0 !dest_sel_in
      |=> acc_out[0] == $past(carry_out)) else $error("carry not in bit 0");
   AST_ROTR_BIT: assert property (s_exec(rotate_right_carry_op) ##0 !dest_sel_in
      |=> acc_out[7] == $past(carry_out)) else $error("carry not in bit 7");
   AST_ROT_ONLY_C: assert property (exec_valid_in && op_in inside {rotate_left_carry_op,
      rotate_right_carry_op} |=> $stable({digit_carry_out, zero_out}))
      else $error("rotate changed digit or zero");
   AST_XOR_LIT: assert property (s_exec(xor_literal_acc_op)
      |=> acc_out == ($past(acc_out) ^ $past(literal_in))) else $error("literal xor wrong");
   AST_XOR_REG_FLAGS: assert property (s_exec(xor_acc_reg_op)
      |=> $stable({carry_out, digit_carry_out})) else $error("xor changed carry or digit");
   AST_SUB_ZERO: assert property (s_exec(subtract_acc_from_reg_op) ##0 !dest_sel_in
      |=> zero_out == (acc_out == 8'h00)) else $error("subtract zero flag wrong");
   AST_DIR_A: assert property (s_exec(direction_load_op) ##0 (file_addr_in == 5'h06)
      |=> dir_a_out == $past(acc_out) && $stable(dir_b_out)) else $error("dir a load wrong");
   AST_DIR_B: assert property (s_exec(direction_load_op) ##0 (file_addr_in == 5'h07)
      |=> dir_b_out == $past(acc_out) && $stable(dir_a_out)) else $error("dir b load wrong");
endmodule
bind rsxs_exec rsxs_exec_chk chk_i (.clock_in, .sys_rst_in, .exec_valid_in, .op_in,
   .file_addr_in, .dest_sel_in, .literal_in, .acc_out, .carry_out, .digit_carry_out,
   .zero_out, .dir_a_out, .dir_b_out);

// ---- test/test_rotate_swap_xor_sub_exec.sv ----
// Random instruction run compared each cycle with a behavioural model.
// Assumes the decoder model drives every datapath input except clock_in and sys_rst_in.
`timescale 1ns/1ps
module test_rotate_swap_xor_sub_exec;
   import rsxs_pkg::*;
   logic       clock_in, sys_rst_in, exec_valid_in, dest_sel_in, carry_out, digit_carry_out;
   logic       zero_out, illegal_dir_out, c, dc, z, ill;
   exec_op_t   op_in;
   logic [4:0] file_addr_in;
   logic [7:0] literal_in, acc_out, dir_a_out, dir_b_out, w, fv, da, db, file_rd_data_out;
   logic [7:0] f [32];
   int         r, cycles, num_errors, n_checks;
   rsxs_exec dut (.clock_in, .sys_rst_in, .exec_valid_in, .op_in, .file_addr_in, .dest_sel_in,
      .literal_in, .acc_out, .carry_out, .digit_carry_out, .zero_out, .dir_a_out,
      .dir_b_out, .file_rd_data_out, .illegal_dir_out);
   rsxs_decoder_model src (.clock_in, .sys_rst_in, .exec_valid_out(exec_valid_in),
      .op_out(op_in), .file_addr_out(file_addr_in), .dest_sel_out(dest_sel_in),
      .literal_out(literal_in));
   task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      clock_in = 1'b0;
      forever #50 clock_in = ~clock_in;
   end
   initial begin
      sys_rst_in = 1'b1;
      repeat (8) @(posedge clock_in);
      #1 sys_rst_in = 1'b0;
      repeat (1500) @(posedge clock_in);
      // Second reset in mid-run must restore every reset value
      #1 sys_rst_in = 1'b1;
      repeat (3) @(posedge clock_in);
      #1 sys_rst_in = 1'b0;
      repeat (1500) @(posedge clock_in);
      wrap_up();
   end
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 4000) begin
         num_errors++;
         wrap_up();
      end
   end
   always @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         {w, c, dc, z, ill, da, db, fv} = {8'h00, 3'h0, 1'b0, 8'hff, 8'hff, 8'h00};
         foreach (f[i]) f[i] = 8'h00;
      end else begin
         ill = 1'b0;
         r = -1;
         fv = f[file_addr_in];
         if (exec_valid_in) case (op_in)
            rotate_left_carry_op: {c, r} = {fv[7], 24'h0, fv[6:0], c};
            rotate_right_carry_op: {c, r} = {fv[0], 24'h0, c, fv[7:1]};
            subtract_acc_from_reg_op: begin
               // Keep the difference 8 bits wide so a borrow never makes r negative
               r = {24'h0, fv - w};
               {c, dc, z} = {fv >= w, fv[3:0] >= w[3:0], fv == w};
            end
            nibble_exchange_op: r = {fv[3:0], fv[7:4]};
            xor_acc_reg_op: {z, r} = {fv == w, 24'h0, fv ^ w};
            xor_literal_acc_op: {z, w} = {literal_in == w, w ^ literal_in};
            direction_load_op: begin
               if (file_addr_in == 5'h06) da = w;
               else if (file_addr_in == 5'h07) db = w;
               else ill = 1'b1;
            end
            default: ;
         endcase
         if (r >= 0 && dest_sel_in) f[file_addr_in] = r[7:0];
         else if (r >= 0) w = r[7:0];
      end
   end
   always @(negedge clock_in) begin
      if (cycles > 0) begin
         chk("acc", w, acc_out);
         chk("carry", {7'h0, c}, {7'h0, carry_out});
         chk("digit", {7'h0, dc}, {7'h0, digit_carry_out});
         chk("zero", {7'h0, z}, {7'h0, zero_out});
         chk("dir_a", da, dir_a_out);
         chk("dir_b", db, dir_b_out);
         chk("illegal", {7'h0, ill}, {7'h0, illegal_dir_out});
         chk("file_rd", fv, file_rd_data_out);
      end
   end
endmodule
